// [bench/tb_bit_test_set_execute.sv]
// Self-checking bench for the bit test and bit set execute block
`timescale 1ns/1ps
module tb_bit_test_set_execute;
	logic                     clock_in;
	logic                     reset_in;
	logic                     instr_valid_in;
	logic [13:0]              instr_in;
	logic [7:0]               file_read_data_in;
	logic [6:0]               file_read_addr_out;
	bit_ops_pkg::file_write_s file_write_out;
	logic                     skip_next_out;
	logic                     no_operation_out;
	logic                     status_write_out;
	logic                     decode_hit_out;
	int                       failures;
	int                       tests_run;

	bit_test_set_execute bit_test_set_execute_i (.clock_in(clock_in), .reset_in(reset_in),
		.instr_valid_in(instr_valid_in), .instr_in(instr_in),
		.file_read_data_in(file_read_data_in), .file_read_addr_out(file_read_addr_out),
		.file_write_out(file_write_out), .skip_next_out(skip_next_out),
		.no_operation_out(no_operation_out), .status_write_out(status_write_out),
		.decode_hit_out(decode_hit_out));

	initial begin
		clock_in = 1'b0;
		forever #2.5 clock_in = ~clock_in;
	end

	task automatic check(input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t exp %h got %h", $time, exp, got);
		end
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// One instruction; flush marks a word presented while the previous skip is discarding
	task automatic op(input logic [1:0] sub, input logic [2:0] b, input logic [6:0] f,
		input logic [7:0] d, input logic flush);
		logic hit;
		logic take;
		hit = !flush && sub != 2'h0;
		take = hit && sub[1] && (d[b] == sub[0]);
		@(negedge clock_in);
		instr_valid_in = 1'b1;
		instr_in = {bit_ops_pkg::GROUP_BIT_OPS, sub, b, f};
		file_read_data_in = d;
		#1;
		check(16'(f), 16'(file_read_addr_out));
		check(16'(hit), 16'(decode_hit_out));
		check(16'(take), 16'(skip_next_out));
		@(posedge clock_in);
		#1;
		check(16'(take), 16'(no_operation_out));
		check(16'h0000, 16'(status_write_out));
		if (hit && sub == bit_ops_pkg::SUB_SET_BIT) begin
			check({1'b1, f, d | (8'h01 << b)}, file_write_out);
		end else begin
			check(16'h0000, 16'(file_write_out.write_en));
		end
	endtask

	// Skip taken at address 127, discarded set word, then skip not taken at address 0
	task automatic test_skip(input logic [1:0] sub);
		logic [7:0] m;
		for (int b = 0; b < 8; b++) begin
			m = 8'h01 << b;
			op(sub, 3'(b), 7'h7F, sub[0] ? m : ~m, 1'b0);
			op(bit_ops_pkg::SUB_SET_BIT, 3'(b), 7'h11, 8'h00, 1'b1);
			op(sub, 3'(b), 7'h00, sub[0] ? ~m : m, 1'b0);
		end
		$display("skip test sub %h done", sub);
	endtask

	// Back-to-back sets, every bit position, then an undecoded clear pattern
	task automatic test_set();
		for (int b = 0; b < 8; b++) begin
			op(bit_ops_pkg::SUB_SET_BIT, 3'(b), 7'(b * 16 + 3), 8'h5A, 1'b0);
		end
		op(bit_ops_pkg::SUB_SET_BIT, 3'h7, 7'h2C, 8'h0A, 1'b0);
		op(2'h0, 3'h3, 7'h05, 8'hFF, 1'b0);
		$display("set test done");
	endtask

	initial begin
		#20000;
		failures++;
		wrap_up();
	end

	initial begin
		failures = 0;
		tests_run = 0;
		reset_in = 1'b1;
		instr_valid_in = 1'b0;
		instr_in = 14'h0000;
		file_read_data_in = 8'h00;
		repeat (5) @(posedge clock_in);
		@(negedge clock_in);
		reset_in = 1'b0;
		test_skip(bit_ops_pkg::SUB_SKIP_LOW);
		test_skip(bit_ops_pkg::SUB_SKIP_HIGH);
		test_set();
		@(negedge clock_in);
		instr_valid_in = 1'b0;
		wrap_up();
	end
endmodule

// [rtl/bit_ops_pkg.sv]
// Package for the bit test and bit set execute block
package bit_ops_pkg;
	localparam logic [1:0]  GROUP_BIT_OPS  = 2'h1;
	localparam logic [1:0]  SUB_SET_BIT    = 2'h1;
	localparam logic [1:0]  SUB_SKIP_LOW   = 2'h2;
	localparam logic [1:0]  SUB_SKIP_HIGH  = 2'h3;
	localparam int          ADDR_LSB       = 0;
	localparam int          BIT_LSB        = 7;
	localparam int          SUB_LSB        = 10;
	localparam int          GROUP_LSB      = 12;
	localparam logic        SKIP_RESET     = 1'h0;
	localparam int          SKIP_CYCLES    = 2;

	typedef struct packed {
		logic [1:0] group;
		logic [1:0] sub;
		logic [2:0] bit_pos;
		logic [6:0] addr;
	} opcode_s;

	typedef struct packed {
		logic       write_en;
		logic [6:0] addr;
		logic [7:0] data;
	} file_write_s;

	typedef enum logic [1:0] {
		ST_RUN  = 2'b01,
		ST_FLUSH = 2'b10
	} exec_state_e;
endpackage

// [rtl/bit_test_set_execute.sv]
// Decode and execute of the bit test skip and bit set instructions
// How it works
// - Skip-if-low pattern skips the next instruction when the selected bit is zero
// - A taken skip discards the fetched word and runs a no-operation: two cycles
// - Skip-if-high pattern skips the next instruction when the selected bit is one
// - Bit-set forces the selected bit to one in one cycle; no status change
// - Address is opcode bits 6:0, bit position bits 9:7
`timescale 1ns/1ps
module bit_test_set_execute (
	input  wire logic                      clock_in,
	input  wire logic                      reset_in,
	input  wire logic                      instr_valid_in,
	input  wire logic [13:0]               instr_in,
	input  wire logic [7:0]                file_read_data_in,
	output logic      [6:0]                file_read_addr_out,
	output bit_ops_pkg::file_write_s       file_write_out,
	output logic                           skip_next_out,
	output logic                           no_operation_out,
	output logic                           status_write_out,
	output logic                           decode_hit_out
);
	bit_ops_pkg::opcode_s     op;
	bit_ops_pkg::exec_state_e state_q;
	bit_ops_pkg::exec_state_e state_d;
	logic                     is_group;
	logic                     skip_when_bit_low;
	logic                     skip_when_bit_high;
	logic                     set_selected_bit;
	logic                     sel_bit;
	logic                     take_skip;
	logic                     active;
	logic [7:0]               bit_mask;

	assign op = bit_ops_pkg::opcode_s'(instr_in);
	// Fetched word in flush cycle is ignored and never decoded
	assign active = instr_valid_in && (state_q == bit_ops_pkg::ST_RUN);
	assign is_group = (op.group == bit_ops_pkg::GROUP_BIT_OPS);
	assign skip_when_bit_low  = active && is_group && (op.sub == bit_ops_pkg::SUB_SKIP_LOW);
	assign skip_when_bit_high = active && is_group && (op.sub == bit_ops_pkg::SUB_SKIP_HIGH);
	assign set_selected_bit   = active && is_group && (op.sub == bit_ops_pkg::SUB_SET_BIT);
	assign decode_hit_out = skip_when_bit_low || skip_when_bit_high || set_selected_bit;

	assign file_read_addr_out = op.addr;
	assign bit_mask = 8'h01 << op.bit_pos;
	assign sel_bit = |(file_read_data_in & bit_mask);

	assign take_skip = (skip_when_bit_low && !sel_bit)
		|| (skip_when_bit_high && sel_bit);
	assign skip_next_out = take_skip;
	// Skip and set never touch flags
	assign status_write_out = 1'b0;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			bit_ops_pkg::ST_RUN: begin
				if (take_skip) begin
					state_d = bit_ops_pkg::ST_FLUSH;
				end
			end
			bit_ops_pkg::ST_FLUSH: begin
				state_d = bit_ops_pkg::ST_RUN;
			end
			default: begin
				state_d = bit_ops_pkg::ST_RUN;
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			state_q <= bit_ops_pkg::ST_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	assign no_operation_out = (state_q == bit_ops_pkg::ST_FLUSH);

	// Write port registered: data outputs come from flops
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			file_write_out <= '0;
		end else begin
			file_write_out.write_en <= set_selected_bit;
			file_write_out.addr     <= op.addr;
			file_write_out.data     <= file_read_data_in | bit_mask;
		end
	end

	property p_skip_low;
		@(posedge clock_in) disable iff (reset_in)
		(skip_when_bit_low && !sel_bit) |=> no_operation_out;
	endproperty
	a_skip_low: assert property (p_skip_low) else $error("low skip not taken");

	property p_skip_high;
		@(posedge clock_in) disable iff (reset_in)
		(skip_when_bit_high && sel_bit) |=> no_operation_out;
	endproperty
	a_skip_high: assert property (p_skip_high) else $error("high skip not taken");

	property p_no_skip;
		@(posedge clock_in) disable iff (reset_in)
		((skip_when_bit_low && sel_bit) || (skip_when_bit_high && !sel_bit))
		|=> !no_operation_out;
	endproperty
	a_no_skip: assert property (p_no_skip) else $error("skip taken wrongly");

	property p_flush_one;
		@(posedge clock_in) disable iff (reset_in)
		no_operation_out |=> !no_operation_out;
	endproperty
	a_flush_one: assert property (p_flush_one) else $error("flush longer than one");

	property p_flush_nodecode;
		@(posedge clock_in) disable iff (reset_in)
		no_operation_out |-> !decode_hit_out;
	endproperty
	a_flush_nodecode: assert property (p_flush_nodecode) else $error("flushed word ran");

	property p_set_write;
		@(posedge clock_in) disable iff (reset_in)
		set_selected_bit |=> (file_write_out.write_en
			&& file_write_out.addr == $past(instr_in[6:0])
			&& file_write_out.data[$past(instr_in[9:7])]);
	endproperty
	a_set_write: assert property (p_set_write) else $error("bit set write wrong");

	property p_set_keep;
		@(posedge clock_in) disable iff (reset_in)
		set_selected_bit |=> ((file_write_out.data & ~$past(bit_mask))
			== ($past(file_read_data_in) & ~$past(bit_mask)));
	endproperty
	a_set_keep: assert property (p_set_keep) else $error("other bits changed");

	property p_no_status;
		@(posedge clock_in) disable iff (reset_in)
		decode_hit_out |-> !status_write_out;
	endproperty
	a_no_status: assert property (p_no_status) else $error("status touched");

	property p_write_only_set;
		@(posedge clock_in) disable iff (reset_in)
		file_write_out.write_en |-> $past(set_selected_bit);
	endproperty
	a_write_only_set: assert property (p_write_only_set) else $error("spurious write");

	// Bit value taken straight from the read port, independent of the mask path
	property p_low_source;
		@(posedge clock_in) disable iff (reset_in)
		skip_when_bit_low |-> (take_skip == !file_read_data_in[instr_in[9:7]]);
	endproperty
	a_low_source: assert property (p_low_source) else $error("low test wrong bit");

	property p_high_source;
		@(posedge clock_in) disable iff (reset_in)
		skip_when_bit_high |-> (take_skip == file_read_data_in[instr_in[9:7]]);
	endproperty
	a_high_source: assert property (p_high_source) else $error("high test wrong bit");

	// A taken skip costs exactly one extra cycle, then execution resumes
	property p_flush_len;
		@(posedge clock_in) disable iff (reset_in)
		take_skip |=> no_operation_out ##1 !no_operation_out;
	endproperty
	a_flush_len: assert property (p_flush_len) else $error("skip not two cycles");

	// A discarded set word must never reach the register file
	property p_flush_no_write;
		@(posedge clock_in) disable iff (reset_in)
		no_operation_out |=> !file_write_out.write_en;
	endproperty
	a_flush_no_write: assert property (p_flush_no_write) else $error("flushed word wrote");

	property p_flush_no_skip;
		@(posedge clock_in) disable iff (reset_in)
		no_operation_out |-> !skip_next_out;
	endproperty
	a_flush_no_skip: assert property (p_flush_no_skip) else $error("flushed word skipped");

	property p_set_no_skip;
		@(posedge clock_in) disable iff (reset_in)
		set_selected_bit |-> !skip_next_out;
	endproperty
	a_set_no_skip: assert property (p_set_no_skip) else $error("bit set skipped");

	property p_idle_quiet;
		@(posedge clock_in) disable iff (reset_in)
		!instr_valid_in |-> (!decode_hit_out && !skip_next_out);
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("decode without valid");

	property p_set_addr;
		@(posedge clock_in) disable iff (reset_in)
		set_selected_bit |-> (file_read_addr_out == instr_in[6:0]);
	endproperty
	a_set_addr: assert property (p_set_addr) else $error("read address wrong");

	// Write goes back to the register that was read, not a later one
	property p_write_addr;
		@(posedge clock_in) disable iff (reset_in)
		file_write_out.write_en |-> (file_write_out.addr == $past(file_read_addr_out));
	endproperty
	a_write_addr: assert property (p_write_addr) else $error("write address wrong");

	property p_mask_one_hot;
		@(posedge clock_in) disable iff (reset_in)
		decode_hit_out |-> $onehot(bit_mask);
	endproperty
	a_mask_one_hot: assert property (p_mask_one_hot) else $error("bit mask not one-hot");

	property p_skip_hit;
		@(posedge clock_in) disable iff (reset_in)
		take_skip |-> decode_hit_out;
	endproperty
	a_skip_hit: assert property (p_skip_hit) else $error("skip without decode");

	c_skip_low: cover property (@(posedge clock_in) skip_when_bit_low && !sel_bit);
	c_skip_high: cover property (@(posedge clock_in) skip_when_bit_high && sel_bit);
	c_set: cover property (@(posedge clock_in) set_selected_bit);
	c_back: cover property (@(posedge clock_in) take_skip ##2 take_skip);
	c_discard: cover property (@(posedge clock_in) no_operation_out && instr_valid_in);
endmodule
